// ---- gfx_dma_defines.svh ----
`ifndef GFX_DMA_DEFINES_SVH
`define GFX_DMA_DEFINES_SVH

// register byte addresses
`define OFS_TABLE_BASE 32'h1FA0_0000
`define OFS_BUF_ADDR 32'h1FA0_0004
`define OFS_SETUP_WIDTH 32'h1FA0_0008
`define OFS_GFX_ADDR 32'h1FA0_000C
`define OFS_STRIDE_LINES 32'h1FA0_0010
`define OFS_KICKOFF 32'h1FA0_0100
`define OFS_BURST_LEN 32'h1FA2_0008
`define OFS_GAP_LEN 32'h1FA2_000C
`define OFS_TRIGGER 32'h1FA7_0000
`define OFS_FIRST_ADDR 32'h1FA8_0004
`define OFS_ADDR_MASK 32'h1FA8_0008
`define OFS_SUBSTITUTE 32'h1FA9_000C

// control word of a descriptor (second word)
`define BIT_END_OF_LIST 31
`define BIT_STRIDE_INC 30
`define BIT_LINE_INC 29
`define FLD_GFX_STEP_HI 27
`define FLD_GFX_STEP_LO 16
`define FLD_MODE_HI 13
`define FLD_MODE_LO 12
`define FLD_WIDTH_HI 11
`define FLD_WIDTH_LO 0

// stride word
`define FLD_HOST_STRIDE_HI 27
`define FLD_HOST_STRIDE_LO 16
`define FLD_LINES_HI 15
`define FLD_LINES_LO 0

// table base and trigger fields
`define FLD_TABLE_HI 27
`define BIT_ARM 31
`define FLD_DEST_HI 28
`define BIT_FIRST_VALID 31
`define FLD_FIRST_HI 27

// descriptor layout
`define DESC_WORDS 3'h5
`define DESC_LAST_IDX 3'h4
`define WORD_BYTES 32'h0000_0004

// reset values
`define RST_WORD 32'h0000_0000
`define RST_BYTE 8'h00
`define RST_ADDR29 29'h0000_0000

`endif

// ---- gfx_dma_pkg.sv ----
package gfx_dma_pkg;

   // transfer direction decoded from the mode field
   typedef enum logic [1:0] {
      mode_read_type = 2'b00,
      mode_accum_type = 2'b01,
      mode_write_type = 2'b10,
      mode_rsvd_type = 2'b11
   } xfer_mode_type;

   // channel sequencer, one-hot
   typedef enum logic [3:0] {
      st_idle = 4'b0001,
      st_fetch = 4'b0010,
      st_line = 4'b0100,
      st_gap = 4'b1000
   } dma_state_type;

endpackage : gfx_dma_pkg

// ---- graphics_dma_and_triple_transfer.sv ----
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "gfx_dma_defines.svh"

//
// How it works
// - descriptor copied into channel registers before data
// - burst length from software only, never from descriptors
// - bursts and gaps sized by 8-bit burst and gap lengths
// - end-of-list flag stops chaining after that descriptor
// - gfx line base steps by gfx stride only if stride enable
// - gfx line increment only if line increment enable
// - gfx stride in bits 27:16 of the control word
// - mode 00 read, 10 write, 01 accumulate
// - scan line byte count from bits 11:0
// - host stride 27:16 added to host address per line
// - lines counted from stride word bits 15:0
// - 32-bit next pointer is the next fetch address
// - table base uses bits 27:0, bits 31:28 ignored
// - DMA starts only in enhanced graphics mode; basic mode does not stop a running chain
// - trigger bit 31 arms or disarms triple transfers
// - trigger bits 28:0 hold gfx destination
// - first-address bit 31 flags a captured start
// - captured start address in bits 27:0
// - mask and substitute registers hold 29 bits each
// - synchronous burst link, one word every two clocks at 25 MHz
// - each link party buffers two words for four-clock round trip
module graphics_dma_and_triple_transfer
   import gfx_dma_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enhanced_graphics_mode,
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output logic xfer_valid,
   output logic [31:0] xfer_host_addr,
   output logic [31:0] xfer_gfx_addr,
   output logic [1:0] xfer_mode,
   input wire logic xfer_ready,
   output logic dma_busy,
   input wire logic blk_wr,
   input wire logic [27:0] blk_addr,
   output logic triple_go,
   output logic [27:0] triple_first,
   output logic [27:0] triple_last,
   output logic [28:0] triple_gfx_addr
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------

   // words in a scan line of given byte width
   function automatic logic [9:0] words_of(input logic [11:0] bytes);
      logic [12:0] sum;
      sum = {1'b0, bytes} + 13'h0003;
      return sum[11:2];
   endfunction : words_of

   // masked dest bits replaced by substitute
   function automatic logic [28:0] substitute(input logic [28:0] dest,
                                              input logic [28:0] mask,
                                              input logic [28:0] subs);
      return (dest & ~mask) | (subs & mask);
   endfunction : substitute

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [31:0] table_base_q;
   logic [31:0] buf_addr_q;
   logic [31:0] ctrl_q;
   logic [31:0] gfx_addr_q;
   logic [31:0] stride_q;
   logic [31:0] next_desc_q;
   logic [31:0] host_ptr_q;
   logic [31:0] host_line_q;
   logic [31:0] gfx_line_q;
   logic [15:0] lines_left_q;
   logic [9:0] words_left_q;
   logic [7:0] burst_len_q;
   logic [7:0] gap_len_q;
   logic [7:0] burst_cnt_q;
   logic [7:0] gap_cnt_q;
   logic [2:0] desc_idx_q;
   dma_state_type state_q;
   logic arm_q;
   logic [28:0] dest_q;
   logic [28:0] mask_q;
   logic [28:0] subs_q;
   logic first_valid_q;
   logic [27:0] first_addr_q;

   logic wr_en;
   logic setup;
   logic kick;
   logic word_done;
   logic line_end;
   logic burst_end;
   logic [11:0] width;
   logic [15:0] line_count;
   logic [31:0] gfx_next_line;
   logic [31:0] rd_d;
   logic hit_d;

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite;
   assign width = ctrl_q[`FLD_WIDTH_HI:`FLD_WIDTH_LO];
   assign line_count = stride_q[`FLD_LINES_HI:`FLD_LINES_LO];
   // kickoff ignored while busy or in basic mode
   assign kick = wr_en && paddr == `OFS_KICKOFF && state_q == st_idle
                 && enhanced_graphics_mode;
   assign word_done = state_q == st_line && xfer_valid && xfer_ready;
   assign line_end = word_done && words_left_q == 10'h001;
   // burst length zero means no limit
   assign burst_end = burst_len_q != `RST_BYTE && burst_cnt_q == burst_len_q - 8'h01;

   // next gfx line base, each step gated
   always_comb begin
      gfx_next_line = gfx_line_q;
      if (ctrl_q[`BIT_STRIDE_INC]) begin
         gfx_next_line = gfx_next_line
            + {20'h00000, ctrl_q[`FLD_GFX_STEP_HI:`FLD_GFX_STEP_LO]};
      end
      if (ctrl_q[`BIT_LINE_INC]) begin
         gfx_next_line = gfx_next_line + {20'h00000, width};
      end
   end

   // ----------------------------------------
   // apb read decode
   // ----------------------------------------
   always_comb begin
      rd_d = `RST_WORD;
      hit_d = 1'b1;
      if (paddr == `OFS_TABLE_BASE) begin
         rd_d = table_base_q;
      end else if (paddr == `OFS_BUF_ADDR) begin
         rd_d = ctrl_q;
      end else if (paddr == `OFS_SETUP_WIDTH) begin
         rd_d = {16'h0000, ctrl_q[15:0]};
      end else if (paddr == `OFS_GFX_ADDR) begin
         rd_d = gfx_addr_q;
      end else if (paddr == `OFS_STRIDE_LINES) begin
         rd_d = {stride_q[31:16], lines_left_q};
      end else if (paddr == `OFS_KICKOFF) begin
         rd_d = `RST_WORD; // reads zero
      end else if (paddr == `OFS_BURST_LEN) begin
         rd_d = {24'h000000, burst_len_q};
      end else if (paddr == `OFS_GAP_LEN) begin
         rd_d = {24'h000000, gap_len_q};
      end else if (paddr == `OFS_TRIGGER) begin
         rd_d = {arm_q, 2'b00, dest_q};
      end else if (paddr == `OFS_FIRST_ADDR) begin
         rd_d = {first_valid_q, 3'b000, first_addr_q};
      end else if (paddr == `OFS_ADDR_MASK) begin
         rd_d = {3'b000, mask_q};
      end else if (paddr == `OFS_SUBSTITUTE) begin
         rd_d = {3'b000, subs_q};
      end else begin
         hit_d = 1'b0;
      end
   end

   // apb answer: ready each access phase, data from setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `RST_WORD;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit_d;
         prdata <= (setup && !pwrite) ? rd_d : `RST_WORD;
      end
   end

   // ----------------------------------------
   // software-loaded settings
   // ----------------------------------------

   // burst and gap static across the chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_base_q <= `RST_WORD;
         burst_len_q <= `RST_BYTE;
         gap_len_q <= `RST_BYTE;
         mask_q <= `RST_ADDR29;
         subs_q <= `RST_ADDR29;
      end else if (wr_en) begin
         if (paddr == `OFS_TABLE_BASE) begin
            table_base_q <= pwdata; // top bits unused
         end else if (paddr == `OFS_BURST_LEN) begin
            burst_len_q <= pwdata[7:0];
         end else if (paddr == `OFS_GAP_LEN) begin
            gap_len_q <= pwdata[7:0];
         end else if (paddr == `OFS_ADDR_MASK) begin
            mask_q <= pwdata[`FLD_DEST_HI:0];
         end else if (paddr == `OFS_SUBSTITUTE) begin
            subs_q <= pwdata[`FLD_DEST_HI:0];
         end
      end
   end

   // ----------------------------------------
   // descriptor chaining sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= st_idle;
         desc_idx_q <= 3'h0;
         mem_req <= 1'b0;
         mem_addr <= `RST_WORD;
         dma_busy <= 1'b0;
      end else begin
         case (state_q)
            st_idle: begin
               if (kick) begin
                  state_q <= st_fetch;
                  desc_idx_q <= 3'h0;
                  mem_req <= 1'b1;
                  mem_addr <= {4'h0, table_base_q[`FLD_TABLE_HI:0]};
                  dma_busy <= 1'b1;
               end
            end
            st_fetch: begin
               if (mem_ack) begin
                  if (desc_idx_q == `DESC_LAST_IDX) begin
                     mem_req <= 1'b0;
                     state_q <= st_line; // data after copy
                  end else begin
                     desc_idx_q <= desc_idx_q + 3'h1;
                     mem_addr <= mem_addr + `WORD_BYTES;
                  end
               end
            end
            st_line: begin
               // empty descriptors skip to the chain decision
               if (lines_left_q == 16'h0000 || width == 12'h000
                   || (line_end && lines_left_q == 16'h0001)) begin
                  if (ctrl_q[`BIT_END_OF_LIST]) begin
                     state_q <= st_idle;
                     dma_busy <= 1'b0;
                  end else begin
                     state_q <= st_fetch;
                     desc_idx_q <= 3'h0;
                     mem_req <= 1'b1;
                     mem_addr <= next_desc_q;
                  end
               end else if (word_done && burst_end && gap_len_q != `RST_BYTE) begin
                  state_q <= st_gap;
               end
            end
            st_gap: begin
               if (gap_cnt_q == 8'h01) begin
                  state_q <= st_line;
               end
            end
            default: begin
               state_q <= st_idle;
            end
         endcase
      end
   end

   // channel registers filled from memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_addr_q <= `RST_WORD;
         ctrl_q <= `RST_WORD;
         stride_q <= `RST_WORD;
         next_desc_q <= `RST_WORD;
      end else if (state_q == st_fetch && mem_ack) begin
         case (desc_idx_q)
            3'h0: buf_addr_q <= mem_rdata;
            3'h1: ctrl_q <= mem_rdata;
            3'h3: stride_q <= mem_rdata;
            3'h4: next_desc_q <= mem_rdata;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // word stream toward the graphics link
   // ----------------------------------------

   // far side buffers two words
   // but each request still drops for a cycle after its word is taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_ptr_q <= `RST_WORD;
         host_line_q <= `RST_WORD;
         gfx_line_q <= `RST_WORD;
         gfx_addr_q <= `RST_WORD;
         lines_left_q <= 16'h0000;
         words_left_q <= 10'h000;
         burst_cnt_q <= `RST_BYTE;
         gap_cnt_q <= `RST_BYTE;
      end else if (state_q == st_fetch && mem_ack) begin
         if (desc_idx_q == 3'h0) begin
            host_ptr_q <= mem_rdata;
            host_line_q <= mem_rdata;
         end else if (desc_idx_q == 3'h2) begin
            gfx_addr_q <= mem_rdata;
            gfx_line_q <= mem_rdata;
         end else if (desc_idx_q == 3'h3) begin
            lines_left_q <= mem_rdata[`FLD_LINES_HI:`FLD_LINES_LO];
         end else if (desc_idx_q == `DESC_LAST_IDX) begin
            words_left_q <= words_of(width);
            burst_cnt_q <= `RST_BYTE;
         end
      end else if (state_q == st_gap) begin
         gap_cnt_q <= gap_cnt_q - 8'h01;
         burst_cnt_q <= `RST_BYTE;
      end else if (word_done) begin
         burst_cnt_q <= burst_end ? `RST_BYTE : burst_cnt_q + 8'h01;
         gap_cnt_q <= gap_len_q;
         if (line_end) begin
            lines_left_q <= lines_left_q - 16'h0001;
            words_left_q <= words_of(width);
            host_line_q <= host_line_q
               + {20'h00000, stride_q[`FLD_HOST_STRIDE_HI:`FLD_HOST_STRIDE_LO]};
            host_ptr_q <= host_line_q
               + {20'h00000, stride_q[`FLD_HOST_STRIDE_HI:`FLD_HOST_STRIDE_LO]};
            gfx_line_q <= gfx_next_line;
            gfx_addr_q <= gfx_next_line;
         end else begin
            words_left_q <= words_left_q - 10'h001;
            host_ptr_q <= host_ptr_q + `WORD_BYTES;
            gfx_addr_q <= gfx_addr_q + `WORD_BYTES;
         end
      end
   end

   // request from flops; low in gaps and line ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_valid <= 1'b0;
         xfer_host_addr <= `RST_WORD;
         xfer_gfx_addr <= `RST_WORD;
         xfer_mode <= 2'b00;
      end else begin
         xfer_mode <= ctrl_q[`FLD_MODE_HI:`FLD_MODE_LO];
         xfer_host_addr <= word_done ? xfer_host_addr : host_ptr_q;
         xfer_gfx_addr <= word_done ? xfer_gfx_addr : gfx_addr_q;
         if (word_done) begin
            xfer_valid <= 1'b0;
         end else begin
            xfer_valid <= state_q == st_line && lines_left_q != 16'h0000
                          && width != 12'h000
                          && xfer_mode_type'(ctrl_q[`FLD_MODE_HI:`FLD_MODE_LO])
                             != mode_rsvd_type;
         end
      end
   end

   // ----------------------------------------
   // triple transfer
   // ----------------------------------------

   // capture wins over a same-cycle trigger write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_q <= 1'b0;
         dest_q <= `RST_ADDR29;
         first_valid_q <= 1'b0;
         first_addr_q <= 28'h000_0000;
         triple_go <= 1'b0;
         triple_first <= 28'h000_0000;
         triple_last <= 28'h000_0000;
         triple_gfx_addr <= `RST_ADDR29;
      end else begin
         triple_go <= 1'b0;
         if (wr_en && paddr == `OFS_TRIGGER) begin
            arm_q <= pwdata[`BIT_ARM];
            dest_q <= pwdata[`FLD_DEST_HI:0];
            first_valid_q <= 1'b0;
         end
         if (arm_q && blk_wr) begin
            if (!first_valid_q) begin
               first_valid_q <= 1'b1;
               first_addr_q <= blk_addr;
            end else begin
               // end-word write-back closes it
               triple_go <= 1'b1;
               triple_first <= first_addr_q;
               triple_last <= blk_addr;
               triple_gfx_addr <= substitute(dest_q, mask_q, subs_q);
               arm_q <= 1'b0;
            end
         end
      end
   end

endmodule : graphics_dma_and_triple_transfer

// ---- graphics_dma_and_triple_transfer_props.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module dma_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic enhanced_graphics_mode,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic xfer_valid,
   input wire logic [31:0] xfer_host_addr,
   input wire logic [31:0] xfer_gfx_addr,
   input wire logic [1:0] xfer_mode,
   input wire logic xfer_ready,
   input wire logic dma_busy,
   input wire logic blk_wr,
   input wire logic triple_go
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ready one cycle after setup
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_access_a: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
      else $error("ready outside access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   // fetch held until taken
   mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("fetch request dropped");
   xfer_hold_a: assert property (xfer_valid && !xfer_ready |=>
      xfer_valid && $stable(xfer_host_addr) && $stable(xfer_gfx_addr) && $stable(xfer_mode))
      else $error("copy request changed");
   xfer_drop_a: assert property (xfer_valid && xfer_ready |=> !xfer_valid)
      else $error("no gap after copy");
   mode_gate_a: assert property (!enhanced_graphics_mode && !dma_busy |=> !dma_busy)
      else $error("chain started in basic mode");
   busy_cover_a: assert property (mem_req || xfer_valid |-> dma_busy)
      else $error("traffic while idle");
   mode_legal_a: assert property (xfer_valid |-> xfer_mode != 2'b11)
      else $error("reserved mode issued");
   go_pulse_a: assert property (triple_go |=> !triple_go)
      else $error("go longer than a cycle");
   go_cause_a: assert property (triple_go |-> $past(blk_wr))
      else $error("go without block write");

   cover property (xfer_valid && xfer_ready);
   cover property (mem_req && mem_ack);
   cover property (triple_go);
   cover property (pslverr);
endmodule : dma_props

bind graphics_dma_and_triple_transfer dma_props dma_props_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .enhanced_graphics_mode(enhanced_graphics_mode), .mem_req(mem_req), .mem_addr(mem_addr),
   .mem_ack(mem_ack), .xfer_valid(xfer_valid), .xfer_host_addr(xfer_host_addr),
   .xfer_gfx_addr(xfer_gfx_addr), .xfer_mode(xfer_mode), .xfer_ready(xfer_ready),
   .dma_busy(dma_busy), .blk_wr(blk_wr), .triple_go(triple_go));

// ---- far_side_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// memory and graphics link partner
// ----------------------------------------
module far_side_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic clear,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   input wire logic xfer_valid,
   input wire logic [31:0] xfer_host_addr,
   input wire logic [31:0] xfer_gfx_addr,
   input wire logic [1:0] xfer_mode,
   output logic xfer_ready
);
   // three chained descriptors at 0x100..0x300
   localparam logic [31:0] desc [15] = '{
      32'h0000_1000, 32'h4100_2008, 32'h0000_8000, 32'h0040_0002, 32'h0000_0200,
      32'h0000_3000, 32'h2010_0004, 32'h0000_9000, 32'h0080_0002, 32'h0000_0300,
      32'h0000_5000, 32'h8000_1004, 32'h0000_A000, 32'h0000_0001, 32'h0000_0400};
   logic [31:0] got_host [16];
   logic [31:0] got_gfx [16];
   logic [1:0] got_mode [16];
   logic [1:0] tick_q;
   int n_xfer = 0;
   int n_fetch = 0;
   int min_gap = 255;
   int last_t = -100;
   int cyc = 0;

   // decode ignores address bits 1:0; stray high bits read zeros
   function automatic logic [31:0] desc_word(input logic [31:0] a);
      if (a[31:12] != 20'h0 || a[11:8] == 4'h0 || a[11:8] > 4'h3 || a[7:0] > 8'h10)
         return 32'h0;
      return desc[(int'(a[11:8]) - 1) * 5 + int'(a[4:2])];
   endfunction : desc_word

   // slow acks alternate cycles; idle data inverted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0000_0000;
         tick_q <= 2'h0;
         xfer_ready <= 1'b0;
      end else begin
         tick_q <= tick_q + 2'h1;
         if (mem_req && !mem_ack && (!slow || tick_q[0])) begin
            mem_ack <= 1'b1;
            mem_rdata <= desc_word(mem_addr);
         end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
         end
         xfer_ready <= !slow || (tick_q != 2'h0);
      end
   end

   // log words taken, tightest spacing
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (clear) begin
         n_xfer = 0;
         n_fetch = 0;
         min_gap = 255;
         last_t = -100;
      end
      if (mem_req && mem_ack)
         n_fetch = n_fetch + 1;
      if (xfer_valid && xfer_ready && n_xfer < 16) begin
         got_host[n_xfer] = xfer_host_addr;
         got_gfx[n_xfer] = xfer_gfx_addr;
         got_mode[n_xfer] = xfer_mode;
         if (cyc - last_t < min_gap)
            min_gap = cyc - last_t;
         last_t = cyc;
         n_xfer = n_xfer + 1;
      end
   end
endmodule : far_side_model

// ---- graphics_dma_and_triple_transfer_tb.sv ----
`timescale 1ns/1ps
`include "gfx_dma_defines.svh"
module graphics_dma_and_triple_transfer_tb import gfx_dma_pkg::*; ();
   localparam logic [31:0] exp_host [7] = '{32'h1000, 32'h1004, 32'h1040, 32'h1044,
      32'h3000, 32'h3080, 32'h5000};
   localparam logic [31:0] exp_gfx [7] = '{32'h8000, 32'h8004, 32'h8100, 32'h8104,
      32'h9000, 32'h9004, 32'hA000};
   localparam xfer_mode_type exp_mode [7] = '{mode_write_type, mode_write_type,
      mode_write_type, mode_write_type, mode_read_type, mode_read_type, mode_accum_type};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic mode_en = 1'b0;
   logic blk_wr = 1'b0;
   logic [27:0] blk_addr = 28'h0;
   logic slow = 1'b0;
   logic clear = 1'b0;
   logic [31:0] prdata, mem_addr, mem_rdata, xfer_host_addr, xfer_gfx_addr, rd;
   logic [27:0] triple_first, triple_last;
   logic [28:0] triple_gfx_addr;
   logic [1:0] xfer_mode;
   logic pready, pslverr, mem_req, mem_ack, xfer_valid, xfer_ready, dma_busy, triple_go, err;
   int fail_count = 0;
   int n_tests = 0;
   int go_count = 0;

   always #20 pclk = ~pclk;

   graphics_dma_and_triple_transfer graphics_dma_and_triple_transfer_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enhanced_graphics_mode(mode_en), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .xfer_valid(xfer_valid),
      .xfer_host_addr(xfer_host_addr), .xfer_gfx_addr(xfer_gfx_addr), .xfer_mode(xfer_mode),
      .xfer_ready(xfer_ready), .dma_busy(dma_busy), .blk_wr(blk_wr), .blk_addr(blk_addr),
      .triple_go(triple_go), .triple_first(triple_first), .triple_last(triple_last),
      .triple_gfx_addr(triple_gfx_addr));

   far_side_model far_side_model_i (.pclk(pclk), .presetn(presetn), .slow(slow),
      .clear(clear), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .xfer_valid(xfer_valid), .xfer_host_addr(xfer_host_addr),
      .xfer_gfx_addr(xfer_gfx_addr), .xfer_mode(xfer_mode), .xfer_ready(xfer_ready));

   // count go pulses
   always @(posedge pclk)
      if (triple_go === 1'b1)
         go_count++;

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic final_report;
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask : chk

   // entered after an edge; request held until pready sampled
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic blk(input logic [27:0] a);
      blk_wr <= 1'b1;
      blk_addr <= a;
      @(posedge pclk);
      blk_wr <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : blk

   // run the chain, compare every word
   task automatic run_dma(input logic [31:0] bl, input logic [31:0] gl, input logic s);
      int n;
      n = 0;
      slow <= s;
      clear <= 1'b1;
      apb(1'b1, `OFS_BURST_LEN, bl);
      clear <= 1'b0;
      apb(1'b1, `OFS_GAP_LEN, gl);
      apb(1'b1, `OFS_KICKOFF, 32'h1);
      while (dma_busy !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      while (dma_busy === 1'b1 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      chk("words", 7, far_side_model_i.n_xfer);
      chk("fetches", 15, far_side_model_i.n_fetch);
      for (int i = 0; i < 7; i++) begin
         chk("host", exp_host[i], far_side_model_i.got_host[i]);
         chk("gfx", exp_gfx[i], far_side_model_i.got_gfx[i]);
         chk("mode", exp_mode[i], far_side_model_i.got_mode[i]);
      end
   endtask : run_dma

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `OFS_TABLE_BASE, 32'h0);
      chk("base rst", `RST_WORD, rd);
      apb(1'b1, `OFS_TABLE_BASE, 32'hF000_0100);
      apb(1'b0, `OFS_TABLE_BASE, 32'h0);
      chk("base", 32'hF000_0100, rd);
      apb(1'b1, `OFS_GAP_LEN, 32'h0000_01A5);
      apb(1'b0, `OFS_GAP_LEN, 32'h0);
      chk("gap", 32'hA5, rd[7:0]);
      apb(1'b0, 32'h1FA0_0200, 32'h0);
      chk("slverr", 1, err);
      $display("test registers done");
      apb(1'b1, `OFS_KICKOFF, 32'h1);
      repeat (10) @(posedge pclk);
      chk("basic busy", 0, dma_busy);
      mode_en <= 1'b1;
      run_dma(32'h0, 32'h0, 1'b0);
      chk("spacing", 2, far_side_model_i.min_gap);
      run_dma(32'h1, 32'h3, 1'b1);
      chk("gap spacing", 1, far_side_model_i.min_gap >= 4);
      apb(1'b0, `OFS_BUF_ADDR, 32'h0);
      chk("ctrl", 32'h8000_1004, rd);
      apb(1'b0, `OFS_SETUP_WIDTH, 32'h0);
      chk("width", 32'h1004, rd[15:0]);
      $display("test dma done");
      apb(1'b1, `OFS_ADDR_MASK, 32'h0000_00FF);
      apb(1'b1, `OFS_SUBSTITUTE, 32'h0000_0055);
      apb(1'b0, `OFS_ADDR_MASK, 32'h0);
      chk("mask", 32'hFF, rd[28:0]);
      apb(1'b0, `OFS_SUBSTITUTE, 32'h0);
      chk("subs", 32'h55, rd[28:0]);
      apb(1'b1, `OFS_TRIGGER, 32'h0ABC_DE00);
      blk(28'h123_4560);
      blk(28'h123_45FC);
      chk("disarmed go", 0, go_count);
      apb(1'b1, `OFS_TRIGGER, 32'h8ABC_DE00);
      apb(1'b0, `OFS_TRIGGER, 32'h0);
      chk("trigger", 32'h2ABC_DE00, {rd[31], rd[28:0]});
      apb(1'b0, `OFS_FIRST_ADDR, 32'h0);
      chk("valid", 0, rd[31]);
      blk(28'h123_4560);
      apb(1'b0, `OFS_FIRST_ADDR, 32'h0);
      chk("captured", 1, rd[31]);
      chk("start", 32'h123_4560, rd[27:0]);
      blk(28'h123_45FC);
      chk("go", 1, go_count);
      chk("first", 32'h123_4560, triple_first);
      chk("last", 32'h123_45FC, triple_last);
      chk("dest", 32'h0ABC_DE55, triple_gfx_addr);
      blk(28'h123_4600);
      chk("late go", 1, go_count);
      $display("test triple done");
      final_report;
   end

   // watchdog far past the test length
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      final_report;
   end
endmodule : graphics_dma_and_triple_transfer_tb
